// file: logic/sbcfg_defs.svh
`ifndef SBCFG_DEFS_SVH
`define SBCFG_DEFS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define SBCFG_ADDR_SWITCH 8'h15
`define SBCFG_ADDR_BUCK 8'h16

// ----------------------------------------
// reset values and writable masks
// ----------------------------------------
`define SBCFG_RST_SWITCH 8'h00
`define SBCFG_RST_BUCK 8'hab
`define SBCFG_MASK_SWITCH 8'h3f
`define SBCFG_MASK_BUCK 8'hbf

// ----------------------------------------
// field positions
// ----------------------------------------
`define SBCFG_SW_CUTOFF_LSB 3
`define SBCFG_SW_DISCHARGE_LSB 0
`define SBCFG_BUCK_LIGHTLOAD_BIT 7
`define SBCFG_BUCK_CODE_LSB 0

// ----------------------------------------
// voltage code map, millivolts
// ----------------------------------------
`define SBCFG_VOLT_BASE_MV 850
`define SBCFG_VOLT_FINE_STEP_MV 10
`define SBCFG_VOLT_KNEE_CODE 50
`define SBCFG_VOLT_KNEE_MV 1350
`define SBCFG_VOLT_COARSE_STEP_MV 25

// ----------------------------------------
// monitor blanking time
// ----------------------------------------
`define SBCFG_BLANK_TIME_US 5000
`define SBCFG_CLK_MHZ 40
`define SBCFG_BLANK_CYCLES (`SBCFG_BLANK_TIME_US * `SBCFG_CLK_MHZ)

`endif

// file: logic/sbcfg_pkg.sv
package sbcfg_pkg;

    // ----------------------------------------
    // register layouts
    // ----------------------------------------
    typedef struct packed {
        logic [1:0] rsvd;
        logic [2:0] cutoff;
        logic [2:0] discharge;
    } sbcfg_sw_cfg_t;

    typedef struct packed {
        logic lightLoad;
        logic rsvd;
        logic [5:0] code;
    } sbcfg_buck_t;

    // ----------------------------------------
    // register port request
    // ----------------------------------------
    typedef struct packed {
        logic wrEn;
        logic rdEn;
        logic [7:0] addr;
        logic [7:0] data;
    } sbcfg_req_t;

    // ----------------------------------------
    // blanking timer states
    // ----------------------------------------
    typedef enum logic [1:0] {
        SBCFG_IDLE = 2'b01,
        SBCFG_BLANK = 2'b10
    } sbcfg_blank_state_t;

endpackage

// file: logic/sbcfg_blank_timer.sv
`timescale 1ns/100ps
`include "sbcfg_defs.svh"

module sbcfg_blank_timer #(
    parameter int BLANK_CYCLES = `SBCFG_BLANK_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic start,
    output logic blanking
);

    localparam int CW = $clog2(BLANK_CYCLES + 1);
    localparam logic [CW-1:0] LOAD = CW'(BLANK_CYCLES - 1);

    sbcfg_pkg::sbcfg_blank_state_t state;
    logic [CW-1:0] count;

    // ----------------------------------------
    // state and counter
    // ----------------------------------------
    // restartable blanking window
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state <= sbcfg_pkg::SBCFG_IDLE;
            count <= '0;
        end else if (start) begin
            state <= sbcfg_pkg::SBCFG_BLANK;
            count <= LOAD;
        end else begin
            unique case (state)
                sbcfg_pkg::SBCFG_IDLE: begin
                    count <= '0;
                end
                sbcfg_pkg::SBCFG_BLANK: begin
                    if (count == '0) begin
                        state <= sbcfg_pkg::SBCFG_IDLE;
                    end else begin
                        count <= count - 1'b1;
                    end
                end
                default: begin
                    state <= sbcfg_pkg::SBCFG_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            blanking <= 1'b0;
        end else if (start) begin
            blanking <= 1'b1;
        end else if (state == sbcfg_pkg::SBCFG_BLANK && count == '0) begin
            blanking <= 1'b0;
        end
    end

endmodule

// file: logic/sbcfg_volt_map.sv
`timescale 1ns/100ps
`include "sbcfg_defs.svh"

module sbcfg_volt_map (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [5:0] code,
    output logic [10:0] millivolt
);

    localparam logic [10:0] BASE = 11'(`SBCFG_VOLT_BASE_MV);
    localparam logic [10:0] FINE = 11'(`SBCFG_VOLT_FINE_STEP_MV);
    localparam logic [5:0] KNEE = 6'(`SBCFG_VOLT_KNEE_CODE);
    localparam logic [10:0] KNEE_MV = 11'(`SBCFG_VOLT_KNEE_MV);
    localparam logic [10:0] COARSE = 11'(`SBCFG_VOLT_COARSE_STEP_MV);
    localparam logic [10:0] RST_MV = 11'(`SBCFG_VOLT_BASE_MV
        + `SBCFG_VOLT_FINE_STEP_MV * (`SBCFG_RST_BUCK & 8'h3f));

    // ----------------------------------------
    // code to millivolts
    // ----------------------------------------
    function automatic logic [10:0] to_mv(input logic [5:0] c);
        logic [10:0] wide;
        wide = {5'h00, c};
        if (c <= KNEE) begin
            to_mv = 11'(BASE + FINE * wide);
        end else begin
            to_mv = 11'(KNEE_MV + COARSE * (wide - {5'h00, KNEE}));
        end
    endfunction

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            millivolt <= RST_MV;
        end else begin
            millivolt <= to_mv(code);
        end
    end

endmodule

// file: logic/sbcfg_regs.sv
`timescale 1ns/100ps
`include "sbcfg_defs.svh"

// Function
// - switch config register at 0x15, all fields reset to zero.
// - bits 5..3 cut switches 3..1 off while power-fail indicator is low.
// - bits 2..0 discharge switches 3..1 outputs whenever the switch is off.
// - buck register at 0x16 resets to 0xab: light-load on, code 2Bh.
// - writes to both registers are refused unless the password unlocks them.
// - each accepted (unlocked) buck register write blanks over/under-voltage monitoring for 5 ms.
// - new voltage code applies only after a go or go-no-discharge command.
// - buck bit 7 selects light-load pulse skipping, 0 forces fixed frequency.
// - code 0..32h is 850 mV plus 10 mV steps, then 25 mV steps.
module sbcfg_regs #(
    parameter int BLANK_CYCLES = `SBCFG_BLANK_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst,
    input sbcfg_pkg::sbcfg_req_t regReq,
    input wire logic writeUnlocked,
    input wire logic voltageApply,
    input wire logic voltage_apply_no_discharge,
    input wire logic power_fail_indicator_n,
    input wire logic [2:0] switchEnable,
    output logic [7:0] regRdData,
    output logic regRdValid,
    output logic writeRefused,
    output logic [2:0] switchOn,
    output logic [2:0] switchDischarge,
    output logic lightLoadMode,
    output logic [5:0] appliedCode,
    output logic [10:0] appliedMillivolt,
    output logic monitorBlank
);

    sbcfg_pkg::sbcfg_sw_cfg_t load_switch_config;
    sbcfg_pkg::sbcfg_buck_t first_buck_converter;
    logic hitSwitch;
    logic hitBuck;
    logic wrSwitch;
    logic wrBuck;
    logic goCmd;
    logic [2:0] next_switchOnVec;
    localparam logic [7:0] BUCK_RST = `SBCFG_RST_BUCK;
    localparam int AW = $clog2(BLANK_CYCLES + 2);
    localparam logic [AW-1:0] AGE_LAST = AW'(BLANK_CYCLES);
    localparam logic [AW-1:0] AGE_DONE = AW'(BLANK_CYCLES + 1);
    logic [AW-1:0] blankAge;

    // ----------------------------------------
    // address decode
    // ----------------------------------------
    assign hitSwitch = regReq.addr == `SBCFG_ADDR_SWITCH;
    assign hitBuck = regReq.addr == `SBCFG_ADDR_BUCK;
    assign wrSwitch = regReq.wrEn && hitSwitch && writeUnlocked;
    assign wrBuck = regReq.wrEn && hitBuck && writeUnlocked;
    assign goCmd = voltageApply || voltage_apply_no_discharge;

    // ----------------------------------------
    // register storage
    // ----------------------------------------
    // switch register reset and write
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            load_switch_config <= `SBCFG_RST_SWITCH;
        end else if (wrSwitch) begin
            load_switch_config <= regReq.data & `SBCFG_MASK_SWITCH;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            first_buck_converter <= `SBCFG_RST_BUCK;
        end else if (wrBuck) begin
            first_buck_converter <= regReq.data & `SBCFG_MASK_BUCK;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            writeRefused <= 1'b0;
        end else begin
            writeRefused <= regReq.wrEn && (hitSwitch || hitBuck) && !writeUnlocked;
        end
    end

    // ----------------------------------------
    // read port
    // ----------------------------------------
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            regRdData <= 8'h00;
            regRdValid <= 1'b0;
        end else begin
            regRdValid <= regReq.rdEn;
            if (regReq.rdEn && hitSwitch) begin
                regRdData <= load_switch_config;
            end else if (regReq.rdEn && hitBuck) begin
                regRdData <= first_buck_converter;
            end else begin
                regRdData <= 8'h00;
            end
        end
    end

    // ----------------------------------------
    // load switch control
    // ----------------------------------------
    genvar i;
    generate
        for (i = 0; i < 3; i++) begin : g_sw
            assign next_switchOnVec[i] = switchEnable[i]
                && !(load_switch_config.cutoff[i] && !power_fail_indicator_n);
        end
    endgenerate

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            switchOn <= 3'h0;
        end else begin
            switchOn <= next_switchOnVec;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            switchDischarge <= 3'h0;
        end else begin
            switchDischarge <= load_switch_config.discharge & ~next_switchOnVec;
        end
    end

    // ----------------------------------------
    // buck converter control
    // ----------------------------------------
    // light-load mode select
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            lightLoadMode <= BUCK_RST[`SBCFG_BUCK_LIGHTLOAD_BIT];
        end else begin
            lightLoadMode <= first_buck_converter.lightLoad;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            appliedCode <= 6'(`SBCFG_RST_BUCK);
        end else if (goCmd) begin
            appliedCode <= first_buck_converter.code;
        end
    end

    sbcfg_volt_map sbcfg_volt_map_i (
        .core_clk(core_clk),
        .rst(rst),
        .code(appliedCode),
        .millivolt(appliedMillivolt)
    );

    sbcfg_blank_timer #(
        .BLANK_CYCLES(BLANK_CYCLES)
    ) sbcfg_blank_timer_i (
        .core_clk(core_clk),
        .rst(rst),
        .start(wrBuck),
        .blanking(monitorBlank)
    );

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    // age of the last accepted buck write
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            blankAge <= AGE_DONE;
        end else if (wrBuck) begin
            blankAge <= AW'(1);
        end else if (blankAge != AGE_DONE) begin
            blankAge <= blankAge + 1'b1;
        end
    end

    property p_reset_values;
        @(posedge core_clk) disable iff (rst)
        $past(rst) |-> (load_switch_config == `SBCFG_RST_SWITCH)
            && (first_buck_converter == `SBCFG_RST_BUCK);
    endproperty
    a_reset_values: assert property (p_reset_values)
        else $error("reset values wrong");

    property p_cutoff;
        @(posedge core_clk) disable iff (rst)
        (load_switch_config.cutoff[0] && !power_fail_indicator_n) |=> !switchOn[0];
    endproperty
    a_cutoff: assert property (p_cutoff)
        else $error("switch stayed on during power fail");

    property p_no_cutoff;
        @(posedge core_clk) disable iff (rst)
        (!load_switch_config.cutoff[1] && switchEnable[1]) |=> switchOn[1];
    endproperty
    a_no_cutoff: assert property (p_no_cutoff)
        else $error("switch dropped without cutoff");

    property p_discharge;
        @(posedge core_clk) disable iff (rst)
        switchDischarge[2] |-> !switchOn[2] && $past(load_switch_config.discharge[2]);
    endproperty
    a_discharge: assert property (p_discharge)
        else $error("discharge while on or disabled");

    property p_refused;
        @(posedge core_clk) disable iff (rst)
        (regReq.wrEn && hitBuck && !writeUnlocked)
            |=> $stable(first_buck_converter) && writeRefused;
    endproperty
    a_refused: assert property (p_refused)
        else $error("locked write changed register");

    property p_refused_sw;
        @(posedge core_clk) disable iff (rst)
        (regReq.wrEn && hitSwitch && !writeUnlocked)
            |=> $stable(load_switch_config) && writeRefused;
    endproperty
    a_refused_sw: assert property (p_refused_sw)
        else $error("locked write changed switch register");

    property p_blank;
        @(posedge core_clk) disable iff (rst)
        wrBuck |=> monitorBlank [*8];
    endproperty
    a_blank: assert property (p_blank)
        else $error("blanking not held after write");

    property p_blank_len;
        @(posedge core_clk) disable iff (rst)
        monitorBlank == (blankAge <= AGE_LAST);
    endproperty
    a_blank_len: assert property (p_blank_len)
        else $error("blanking length wrong");

    property p_apply;
        @(posedge core_clk) disable iff (rst)
        !goCmd |=> $stable(appliedCode);
    endproperty
    a_apply: assert property (p_apply)
        else $error("code changed without go");

    property p_apply_go;
        @(posedge core_clk) disable iff (rst)
        goCmd |=> appliedCode == $past(first_buck_converter.code);
    endproperty
    a_apply_go: assert property (p_apply_go)
        else $error("go did not apply code");

    property p_light;
        @(posedge core_clk) disable iff (rst)
        wrBuck |=> ##1 lightLoadMode == $past(regReq.data[7], 2);
    endproperty
    a_light: assert property (p_light)
        else $error("light-load mode not following bit 7");

    property p_knee;
        @(posedge core_clk) disable iff (rst)
        appliedCode == 6'h32 |=> appliedMillivolt == 11'h546;
    endproperty
    a_knee: assert property (p_knee)
        else $error("knee voltage wrong");

    property p_rsvd;
        @(posedge core_clk) disable iff (rst)
        regRdValid |-> !regRdData[6];
    endproperty
    a_rsvd: assert property (p_rsvd)
        else $error("reserved bit read nonzero");

    property p_rsvd_store;
        @(posedge core_clk) disable iff (rst)
        (load_switch_config.rsvd == 2'h0) && (first_buck_converter.rsvd == 1'h0);
    endproperty
    a_rsvd_store: assert property (p_rsvd_store)
        else $error("reserved bit stored nonzero");

    property p_read_buck;
        @(posedge core_clk) disable iff (rst)
        (regReq.rdEn && hitBuck)
            |=> regRdValid && (regRdData == $past(first_buck_converter));
    endproperty
    a_read_buck: assert property (p_read_buck)
        else $error("buck register read back wrong");

    c_go: cover property (@(posedge core_clk) disable iff (rst) wrBuck ##[1:20] goCmd);
    c_cut: cover property (@(posedge core_clk) disable iff (rst)
        switchEnable[0] && !switchOn[0]);
    c_refuse: cover property (@(posedge core_clk) disable iff (rst) writeRefused);
    c_blank_end: cover property (@(posedge core_clk) disable iff (rst) $fell(monitorBlank));
    c_go_nodis: cover property (@(posedge core_clk) disable iff (rst)
        voltage_apply_no_discharge && !voltageApply);

endmodule

// file: tb/sbcfg_host_model.sv
`timescale 1ns/100ps

module sbcfg_host_model (
    input wire logic core_clk,
    output sbcfg_pkg::sbcfg_req_t regReq,
    output logic voltageApply,
    output logic voltage_apply_no_discharge,
    input wire logic [7:0] regRdData,
    input wire logic regRdValid,
    input wire logic writeRefused
);
    initial begin
        regReq = '0;
        voltageApply = 1'b0;
        voltage_apply_no_discharge = 1'b0;
    end

    // ----------------------------------------
    // register port cycles
    // ----------------------------------------
    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data,
                             output logic refused);
        @(posedge core_clk);
        regReq <= '{wrEn: 1'b1, rdEn: 1'b0, addr: addr, data: data};
        @(posedge core_clk);
        regReq <= '0;
        @(negedge core_clk);
        refused = writeRefused;
    endtask

    // data only counts when the valid strobe came back
    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
        @(posedge core_clk);
        regReq <= '{wrEn: 1'b0, rdEn: 1'b1, addr: addr, data: 8'h00};
        @(posedge core_clk);
        regReq <= '0;
        @(negedge core_clk);
        data = (regRdValid === 1'b1) ? regRdData : 8'hxx;
    endtask

    task automatic apply_go(input logic noDischarge);
        @(posedge core_clk);
        voltageApply <= !noDischarge;
        voltage_apply_no_discharge <= noDischarge;
        @(posedge core_clk);
        voltageApply <= 1'b0;
        voltage_apply_no_discharge <= 1'b0;
    endtask
endmodule

// file: tb/switch_and_buck_config_regs_tb.sv
`timescale 1ns/100ps

module switch_and_buck_config_regs_tb;
    localparam int BLANK = 20;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic writeUnlocked = 1'b0;
    logic power_fail_indicator_n = 1'b1;
    logic [2:0] switchEnable = 3'b000;
    sbcfg_pkg::sbcfg_req_t regReq;
    logic voltageApply;
    logic voltage_apply_no_discharge;
    logic [7:0] regRdData;
    logic regRdValid;
    logic writeRefused;
    logic [2:0] switchOn;
    logic [2:0] switchDischarge;
    logic lightLoadMode;
    logic [5:0] appliedCode;
    logic [10:0] appliedMillivolt;
    logic monitorBlank;
    int miscompares = 0;
    int total_checks = 0;

    always #12.5 core_clk = ~core_clk;

    sbcfg_regs #(.BLANK_CYCLES(BLANK)) sbcfg_regs_i (
        .core_clk(core_clk), .rst(rst), .regReq(regReq), .writeUnlocked(writeUnlocked),
        .voltageApply(voltageApply), .voltage_apply_no_discharge(voltage_apply_no_discharge),
        .power_fail_indicator_n(power_fail_indicator_n), .switchEnable(switchEnable),
        .regRdData(regRdData), .regRdValid(regRdValid), .writeRefused(writeRefused),
        .switchOn(switchOn), .switchDischarge(switchDischarge), .lightLoadMode(lightLoadMode),
        .appliedCode(appliedCode), .appliedMillivolt(appliedMillivolt),
        .monitorBlank(monitorBlank)
    );

    sbcfg_host_model sbcfg_host_model_i (
        .core_clk(core_clk), .regReq(regReq), .voltageApply(voltageApply),
        .voltage_apply_no_discharge(voltage_apply_no_discharge), .regRdData(regRdData),
        .regRdValid(regRdValid), .writeRefused(writeRefused)
    );

    // ----------------------------------------
    // compare and report
    // ----------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("checks=%0d miscompares=%0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    function automatic logic [15:0] mv(input logic [5:0] c);
        if (c <= 6'h32) begin
            return 16'h352 + 16'h00a * c;
        end
        return 16'h546 + 16'h019 * (c - 6'h32);
    endfunction

    // count the blanking length seen after a buck write
    task automatic blank_len(input int exp);
        int n;
        n = 0;
        while (monitorBlank === 1'b1 && n < 40) begin
            n++;
            @(negedge core_clk);
        end
        check(16'(n), 16'(exp));
        if (n >= 40) begin
            test_done();
        end
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        logic [7:0] d;
        logic ref_;
        logic [7:0] cfgs [4];
        logic [5:0] codes [5];
        logic [2:0] en;
        logic [2:0] on;
        cfgs = '{8'h38, 8'h07, 8'h2e, 8'h15};
        codes = '{6'h00, 6'h32, 6'h33, 6'h3f, 6'h2b};
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        sbcfg_host_model_i.read_reg(8'h15, d);
        check(d, 8'h00);
        sbcfg_host_model_i.read_reg(8'h16, d);
        check(d, 8'hab);
        check({lightLoadMode, 1'b0, appliedCode}, 8'hab);
        check(appliedMillivolt, 16'h500);
        sbcfg_host_model_i.read_reg(8'h20, d);
        check(d, 8'h00);
        sbcfg_host_model_i.write_reg(8'h16, 8'h05, ref_);
        check(ref_, 1'b1);
        check(monitorBlank, 1'b0);
        sbcfg_host_model_i.read_reg(8'h16, d);
        check(d, 8'hab);
        sbcfg_host_model_i.write_reg(8'h15, 8'h3f, ref_);
        check(ref_, 1'b1);
        sbcfg_host_model_i.read_reg(8'h15, d);
        check(d, 8'h00);
        @(posedge core_clk) writeUnlocked <= 1'b1;
        sbcfg_host_model_i.write_reg(8'h16, 8'hff, ref_);
        check(ref_, 1'b0);
        blank_len(BLANK);
        sbcfg_host_model_i.read_reg(8'h16, d);
        check(d, 8'hbf);
        check(appliedCode, 6'h2b);
        for (int i = 0; i < 5; i++) begin
            sbcfg_host_model_i.write_reg(8'h16, {i[0], 1'b1, codes[i]}, ref_);
            blank_len(BLANK);
            check(appliedCode, codes[(i + 4) % 5]);
            check(lightLoadMode, i[0]);
            sbcfg_host_model_i.apply_go(i[0]);
            repeat (2) @(negedge core_clk);
            check(appliedCode, codes[i]);
            check(appliedMillivolt, mv(codes[i]));
        end
        sbcfg_host_model_i.write_reg(8'h15, 8'hff, ref_);
        sbcfg_host_model_i.read_reg(8'h15, d);
        check(d, 8'h3f);
        for (int c = 0; c < 4; c++) begin
            sbcfg_host_model_i.write_reg(8'h15, cfgs[c], ref_);
            for (int k = 0; k < 4; k++) begin
                en = k[1] ? 3'b010 : 3'b111;
                @(posedge core_clk);
                switchEnable <= en;
                power_fail_indicator_n <= k[0];
                repeat (3) @(negedge core_clk);
                on = en & ~(cfgs[c][5:3] & {3{~k[0]}});
                check(switchOn, on);
                check(switchDischarge, cfgs[c][2:0] & ~on);
            end
        end
        test_done();
    end
endmodule
